// file: csp_clock_select.sv
`timescale 1ns/1ps
// What this block does
// - Fast RC divided by selectable postscale factor
// - Power-on source taken from configuration fields
// - Three-bit configuration code selects clock mode
// - Submode picks primary crystal or external clock
// - Erased configuration starts in divided fast RC
// - System clock halved for instruction clock
// - PLL input divided by two through 33
// - Feedback factor multiplies VCO input
// - VCO output divided by 2, 4, 8
// - PLL output is input times M over N1N2
// - Feedback factor is field plus two
// - Postscale decode, code 10 reserved
// - Fast RC postscale decode, 111 gives 256
// - Control writes ignored without unlock sequence
// - Current source field reports active source
// - Requested source field, reset from configuration
// - Source lock bit freezes clock switching while the clock monitor is disabled
// - Pin lock bit rejects pin select writes
// - PLL lock flag only when locked and used
// - Clock fail flag sticky until software clears or a valid switch starts
// - Secondary oscillator enable bit
// - Switch request bit clears when switch completes
// - Slow RC always feeds watchdog and monitor
// - Unimplemented bits read as zero
module csp_clock_select (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address and data
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // AXI4-Lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [3:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // Nonvolatile configuration
    input  wire logic [2:0]  initial_source_config,
    input  wire logic [1:0]  primary_submode_config,
    input  wire logic        switch_enable_config,
    input  wire logic        monitor_enable_config,
    // Oscillator status pins
    input  wire logic        source_ready_pin,
    input  wire logic        pll_lock_pin,
    input  wire logic        clock_fail_pin,
    // Clock source control
    output logic [2:0]       active_source,
    output logic             source_change,
    output logic             fast_rc_enable,
    output logic             slow_rc_enable,
    output logic             primary_enable,
    output logic [1:0]       primary_submode,
    output logic             secondary_enable,
    output logic             pll_enable,
    output logic             switch_busy,
    // Divider settings, instruction clock enable and pin select write permission
    output logic [8:0]       fast_rc_divide,
    output logic [5:0]       pll_prescale,
    output logic [9:0]       pll_multiplier,
    output logic [3:0]       pll_postscale,
    output logic             instr_clk_en,
    output logic             pin_select_write_ok
);

    function automatic logic uses_pll(input logic [2:0] src);
        uses_pll = (src == csp_pkg::SRC_FRC_PLL) ||
                   (src == csp_pkg::SRC_PRI_PLL);
    endfunction : uses_pll

    function automatic logic is_primary(input logic [2:0] src);
        is_primary = (src == csp_pkg::SRC_PRI) ||
                     (src == csp_pkg::SRC_PRI_PLL);
    endfunction : is_primary

    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb);
        merge = {strb[1] ? new_v[15:8] : old_v[15:8],
                 strb[0] ? new_v[7:0] : old_v[7:0]};
    endfunction : merge

    csp_pkg::csp_state_t state_reg;
    csp_pkg::csp_state_t state_next;

    logic [2:0]  cur_src_reg;
    logic [2:0]  req_src_reg;
    logic [2:0]  target_reg;
    logic        src_lock_reg;
    logic        pin_lock_reg;
    logic        clk_fail_reg;
    logic        sec_en_reg;
    logic        sw_req_reg;
    logic [15:0] clk_div_reg;
    logic [15:0] pll_fbd_reg;
    logic        cfg_loaded_reg;
    logic        sw_en_reg;
    logic        mon_en_reg;
    logic [1:0]  submode_reg;
    logic [1:0]  unlock_reg;
    logic [3:0]  settle_reg;
    logic        half_reg;
    logic        change_reg;
    logic [2:0]  sync1_reg;
    logic [2:0]  sync2_reg;
    logic        aw_full_reg;
    logic        w_full_reg;
    logic [3:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;

    // Synchronised pins
    wire ready_s = sync2_reg[0];
    wire lock_s  = sync2_reg[1];
    wire fail_s  = sync2_reg[2];

    // Bus decode
    wire wr_fire  = aw_full_reg && w_full_reg && !bvalid_reg;
    wire rd_fire  = s_axi_arvalid && !rvalid_reg;
    wire wr_osc   = wr_fire && (aw_addr_reg == csp_pkg::OFS_OSC_CTRL);
    wire wr_div   = wr_fire && (aw_addr_reg == csp_pkg::OFS_CLK_DIV);
    wire wr_fbd   = wr_fire && (aw_addr_reg == csp_pkg::OFS_PLL_FBD);
    wire wr_key   = wr_fire && (aw_addr_reg == csp_pkg::OFS_UNLOCK);
    wire wr_map   = wr_osc || wr_div || wr_fbd || wr_key;
    wire osc_ok   = wr_osc && unlock_reg[1];
    wire lock_eff = sw_en_reg && !mon_en_reg && src_lock_reg;

    // Register images
    wire pll_lock_flag = lock_s && uses_pll(cur_src_reg);
    wire [15:0] osc_val = {1'b0, cur_src_reg, 1'b0, req_src_reg,
                           src_lock_reg, pin_lock_reg, pll_lock_flag,
                           1'b0, clk_fail_reg, 1'b0, sec_en_reg,
                           sw_req_reg};
    wire [15:0] osc_new = merge(osc_val, w_data_reg[15:0], w_strb_reg[1:0]);
    wire [15:0] div_new = merge(clk_div_reg, w_data_reg[15:0],
                                w_strb_reg[1:0]) & csp_pkg::CLK_DIV_MASK;
    wire [15:0] fbd_new = merge(pll_fbd_reg, w_data_reg[15:0],
                                w_strb_reg[1:0]) & csp_pkg::PLL_FBD_MASK;
    wire [15:0] key_new = merge(16'h0000, w_data_reg[15:0],
                                w_strb_reg[1:0]);

    wire [15:0] rd_val =
        (s_axi_araddr == csp_pkg::OFS_OSC_CTRL) ? osc_val :
        (s_axi_araddr == csp_pkg::OFS_CLK_DIV)  ? clk_div_reg :
        (s_axi_araddr == csp_pkg::OFS_PLL_FBD)  ? pll_fbd_reg : 16'h0000;
    wire rd_map = (s_axi_araddr == csp_pkg::OFS_OSC_CTRL) ||
                  (s_axi_araddr == csp_pkg::OFS_CLK_DIV)  ||
                  (s_axi_araddr == csp_pkg::OFS_PLL_FBD)  ||
                  (s_axi_araddr == csp_pkg::OFS_UNLOCK);

    // Switch sequencing
    wire start_req = osc_ok && osc_new[csp_pkg::SW_REQ_BIT] &&
                     sw_en_reg && !lock_eff && (state_reg == csp_pkg::ST_IDLE);
    wire redundant = (req_src_reg == cur_src_reg);
    wire valid_sw  = (state_reg == csp_pkg::ST_START) && !redundant;
    wire new_ok    = ready_s && (!uses_pll(target_reg) || lock_s);
    wire settle_end = (state_reg == csp_pkg::ST_SETTLE) &&
                      (settle_reg == csp_pkg::SETTLE_CYCLES - 4'h1);

    always_comb
    begin
        case (state_reg)
            csp_pkg::ST_IDLE:
                state_next = sw_req_reg ? csp_pkg::ST_START : csp_pkg::ST_IDLE;
            csp_pkg::ST_START:
                state_next = redundant ? csp_pkg::ST_IDLE : csp_pkg::ST_WAIT;
            csp_pkg::ST_WAIT:
                state_next = new_ok ? csp_pkg::ST_SETTLE : csp_pkg::ST_WAIT;
            csp_pkg::ST_SETTLE:
                state_next = settle_end ? csp_pkg::ST_IDLE
                                        : csp_pkg::ST_SETTLE;
            default:
                state_next = csp_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg  <= csp_pkg::ST_IDLE;
            settle_reg <= 4'h0;
            target_reg <= csp_pkg::SRC_FRC;
            change_reg <= 1'b0;
            half_reg   <= 1'b0;
            sync1_reg  <= 3'h0;
            sync2_reg  <= 3'h0;
        end
        else
        begin
            state_reg  <= state_next;
            settle_reg <= (state_reg == csp_pkg::ST_SETTLE) ?
                          settle_reg + 4'h1 : 4'h0;
            if (valid_sw)
                target_reg <= req_src_reg;
            change_reg <= settle_end;
            half_reg   <= !half_reg;
            sync1_reg  <= {clock_fail_pin, pll_lock_pin, source_ready_pin};
            sync2_reg  <= sync1_reg;
        end
    end

    // Oscillator control register and configuration capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_loaded_reg <= 1'b0;
            cur_src_reg    <= csp_pkg::SRC_FRC;
            req_src_reg    <= csp_pkg::SRC_FRC;
            sw_en_reg      <= 1'b0;
            mon_en_reg     <= 1'b0;
            submode_reg    <= csp_pkg::SUB_EXT_CLK;
            src_lock_reg   <= 1'b0;
            pin_lock_reg   <= 1'b0;
            clk_fail_reg   <= 1'b0;
            sec_en_reg     <= 1'b0;
            sw_req_reg     <= 1'b0;
            unlock_reg     <= 2'h0;
        end
        else if (!cfg_loaded_reg)
        begin
            cfg_loaded_reg <= 1'b1;
            cur_src_reg    <= initial_source_config;
            req_src_reg    <= initial_source_config;
            sw_en_reg      <= switch_enable_config;
            mon_en_reg     <= monitor_enable_config;
            submode_reg    <= primary_submode_config;
        end
        else
        begin
            if (settle_end)
                cur_src_reg <= target_reg;
            if (osc_ok && !lock_eff)
                req_src_reg <= osc_new[csp_pkg::REQ_SRC_LSB +: 3];
            if (osc_ok)
            begin
                src_lock_reg <= osc_new[csp_pkg::SRC_LOCK_BIT];
                pin_lock_reg <= osc_new[csp_pkg::PIN_LOCK_BIT];
                sec_en_reg   <= osc_new[csp_pkg::SEC_EN_BIT];
            end
            if (fail_s)
                clk_fail_reg <= 1'b1;
            else if (valid_sw ||
                     (osc_ok && !osc_new[csp_pkg::CLK_FAIL_BIT]))
                clk_fail_reg <= 1'b0;
            if (start_req)
                sw_req_reg <= 1'b1;
            else if (settle_end || ((state_reg == csp_pkg::ST_START) &&
                                    redundant))
                sw_req_reg <= 1'b0;
            if (wr_key)
                unlock_reg <= (key_new == csp_pkg::UNLOCK_KEY_B &&
                               unlock_reg[0]) ? 2'b10 :
                              (key_new == csp_pkg::UNLOCK_KEY_A) ? 2'b01
                                                                 : 2'b00;
            else if (wr_map)
                unlock_reg <= 2'h0;
        end
    end

    // Divider registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            clk_div_reg <= csp_pkg::CLK_DIV_RST;
            pll_fbd_reg <= csp_pkg::PLL_FBD_RST;
        end
        else
        begin
            if (wr_div)
                clk_div_reg <= div_new;
            if (wr_fbd)
                pll_fbd_reg <= fbd_new;
        end
    end

    // AXI4-Lite slave
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_full_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg  <= 32'h0000_0000;
            w_strb_reg  <= 4'h0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= csp_pkg::RESP_OKAY;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= csp_pkg::RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_full_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_full_reg <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_full_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            else if (wr_fire)
                w_full_reg <= 1'b0;
            if (wr_fire)
            begin
                bvalid_reg <= 1'b1;
                bresp_reg  <= wr_map ? csp_pkg::RESP_OKAY
                                     : csp_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                bvalid_reg <= 1'b0;
            if (rd_fire)
            begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= {16'h0000, rd_val};
                rresp_reg  <= rd_map ? csp_pkg::RESP_OKAY
                                     : csp_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready  = !w_full_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    // Source control outputs
    wire switching = (state_reg != csp_pkg::ST_IDLE);
    wire [2:0] frc_code = clk_div_reg[csp_pkg::FRC_DIV_LSB +: 3];
    wire [1:0] post_code = clk_div_reg[csp_pkg::PLL_POST_LSB +: 2];

    assign active_source    = cur_src_reg;
    assign source_change    = change_reg;
    assign switch_busy      = switching;
    assign slow_rc_enable   = 1'b1;
    assign fast_rc_enable   = !cur_src_reg[2] || cur_src_reg[1] ||
                              (switching && (!target_reg[2] || target_reg[1]))
                              ? !(is_primary(cur_src_reg) && !switching)
                              : 1'b0;
    assign primary_enable   = is_primary(cur_src_reg) ||
                              (switching && is_primary(target_reg));
    assign primary_submode  = submode_reg;
    assign secondary_enable = sec_en_reg ||
                              (cur_src_reg == csp_pkg::SRC_SEC) ||
                              (switching && target_reg == csp_pkg::SRC_SEC);
    assign pll_enable       = uses_pll(cur_src_reg) ||
                              (switching && uses_pll(target_reg));
    assign fast_rc_divide   = (frc_code == 3'h7) ? 9'h100
                                                 : 9'h001 << frc_code;
    assign pll_prescale     = {1'b0, clk_div_reg[csp_pkg::PLL_PRE_LSB +: 5]}
                              + 6'h02;
    assign pll_multiplier   = {1'b0, pll_fbd_reg[8:0]} + 10'h002;
    assign pll_postscale    = (post_code == 2'h0) ? 4'h2 :
                              (post_code == 2'h1) ? 4'h4 :
                              (post_code == 2'h3) ? 4'h8 : 4'h0;
    assign instr_clk_en     = half_reg;
    assign pin_select_write_ok = !pin_lock_reg;

    a_fail_sticky: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (fail_s && cfg_loaded_reg) |=> clk_fail_reg)
        else $error("clock fail flag lost");
    a_locked_write: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (wr_osc && !unlock_reg[1] && cfg_loaded_reg) |=> $stable(req_src_reg))
        else $error("locked write changed request");
    a_no_switch_off: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (cfg_loaded_reg && !sw_en_reg) |-> !sw_req_reg)
        else $error("switch request set while switching disabled");
    a_lock_unused: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !uses_pll(cur_src_reg) |-> !osc_val[csp_pkg::PLL_LOCK_BIT])
        else $error("lock flag without pll in use");
    a_settle_time: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(state_reg == csp_pkg::ST_SETTLE) |->
            ##9 (state_reg == csp_pkg::ST_SETTLE) ##1
            (state_reg == csp_pkg::ST_IDLE && cur_src_reg == target_reg))
        else $error("settle length wrong");
    a_cur_stable: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (cfg_loaded_reg && !settle_end) |=> $stable(cur_src_reg))
        else $error("source moved outside switch point");
    a_frc_div256: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (frc_code == 3'h7) |-> (fast_rc_divide == 9'h100))
        else $error("fast rc divide 256 wrong");
    a_post_div8: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (post_code == 2'h3) |-> (pll_postscale == 4'h8))
        else $error("postscale 8 wrong");
    a_instr_half: assert property (@(posedge aclk)
        disable iff (!aresetn)
        instr_clk_en |=> !instr_clk_en ##1 instr_clk_en)
        else $error("instruction clock not halved");
    a_src_frozen: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (lock_eff && state_reg == csp_pkg::ST_IDLE && !sw_req_reg) |=>
            !sw_req_reg)
        else $error("switch started while source locked");

endmodule : csp_clock_select

// file: csp_pkg.sv
package csp_pkg;

    // Register byte offsets
    localparam logic [3:0] OFS_OSC_CTRL = 4'h0;
    localparam logic [3:0] OFS_CLK_DIV  = 4'h4;
    localparam logic [3:0] OFS_PLL_FBD  = 4'h8;
    localparam logic [3:0] OFS_UNLOCK   = 4'hC;

    // Oscillator control field positions
    localparam int CUR_SRC_LSB  = 12;
    localparam int REQ_SRC_LSB  = 8;
    localparam int SRC_LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int CLK_FAIL_BIT = 3;
    localparam int SEC_EN_BIT   = 1;
    localparam int SW_REQ_BIT   = 0;

    // Clock divisor field positions, writable mask and reset value
    localparam int          FRC_DIV_LSB  = 8;
    localparam int          PLL_POST_LSB = 6;
    localparam int          PLL_PRE_LSB  = 0;
    localparam logic [15:0] CLK_DIV_MASK = 16'h07DF;
    localparam logic [15:0] CLK_DIV_RST  = 16'h0040;

    // PLL feedback writable mask and reset value
    localparam logic [15:0] PLL_FBD_MASK = 16'h01FF;
    localparam logic [15:0] PLL_FBD_RST  = 16'h0030;

    // Unlock keys, written in this order to the unlock register
    localparam logic [15:0] UNLOCK_KEY_A = 16'h00A5;
    localparam logic [15:0] UNLOCK_KEY_B = 16'h005A;

    // Source codes
    localparam logic [2:0] SRC_FRC      = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL  = 3'h1;
    localparam logic [2:0] SRC_PRI      = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL  = 3'h3;
    localparam logic [2:0] SRC_SEC      = 3'h4;
    localparam logic [2:0] SRC_SLOW_RC  = 3'h5;
    localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FRC_DIVN = 3'h7;

    // Primary submodes
    localparam logic [1:0] SUB_FAST_XTAL = 2'h2;
    localparam logic [1:0] SUB_STD_XTAL  = 2'h1;
    localparam logic [1:0] SUB_EXT_CLK   = 2'h0;

    // Cycles of the new source before the multiplexer moves
    localparam logic [3:0] SETTLE_CYCLES = 4'hA;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'b0001,
        ST_START  = 4'b0010,
        ST_WAIT   = 4'b0100,
        ST_SETTLE = 4'b1000
    } csp_state_t;

endpackage : csp_pkg

// file: csp_osc_model.sv
`timescale 1ns/1ps
module csp_osc_model (
    // Clock and oscillator enables
    input  wire logic       aclk,
    input  wire logic [2:0] osc_en,
    input  wire logic       pll_en,
    // Bench controls
    input  wire logic [7:0] delay,
    input  wire logic       fail_cmd,
    // Status pins
    output logic            source_ready_pin,
    output logic            pll_lock_pin,
    output logic            clock_fail_pin
);
    logic [2:0] en_q    = 3'h0;
    logic [7:0] osc_cnt = 8'h00;
    logic [7:0] pll_cnt = 8'h00;

    // Start-up timer restarts whenever the set of running sources changes
    always @(posedge aclk)
    begin
        en_q    <= osc_en;
        osc_cnt <= (osc_en != en_q) ? 8'h00
                                     : osc_cnt + {7'h00, osc_cnt != 8'hFF};
        pll_cnt <= !pll_en ? 8'h00 : pll_cnt + {7'h00, pll_cnt != 8'hFF};
    end

    // Ready and lock only after the start-up delay, lock drops with enable
    assign source_ready_pin = (osc_en == en_q) && (osc_cnt >= delay);
    assign pll_lock_pin     = pll_en && (pll_cnt >= delay);
    assign clock_fail_pin   = fail_cmd;
endmodule : csp_osc_model

// file: csp_clock_select_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module csp_clock_select_bench;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0;
    logic        rr = 0, fail_cmd = 0, cfg_sw = 1;
    logic [3:0]  awa = 0, ara = 0;
    logic [2:0]  cfg_src = 3'h7;
    logic [1:0]  cfg_sub = 2'h2;
    logic [31:0] wd = 0;
    logic [7:0]  delay = 8'h03;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, primary_submode;
    logic [2:0]  active_source;
    logic [8:0]  fast_rc_divide;
    logic [5:0]  pll_prescale;
    logic [9:0]  pll_multiplier;
    logic [3:0]  pll_postscale;
    logic        awr, wr, bv, arr, rv, source_change, fast_rc_enable;
    logic        slow_rc_enable, primary_enable, secondary_enable, pll_enable;
    logic        switch_busy, instr_clk_en, pin_select_write_ok;
    logic        source_ready_pin, pll_lock_pin, clock_fail_pin;
    int          n_errors = 0, checks_done = 0, n_chg = 0;

    always #50 aclk = ~aclk;
    always @(posedge aclk) if (source_change === 1'b1) n_chg++;

    csp_clock_select i_csp_clock_select (
        .aclk, .aresetn,
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'h3), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp, .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata, .s_axi_rresp,
        .initial_source_config(cfg_src), .primary_submode_config(cfg_sub),
        .switch_enable_config(cfg_sw), .monitor_enable_config(1'b0),
        .source_ready_pin, .pll_lock_pin, .clock_fail_pin,
        .active_source, .source_change, .fast_rc_enable, .slow_rc_enable,
        .primary_enable, .primary_submode, .secondary_enable, .pll_enable,
        .switch_busy, .fast_rc_divide, .pll_prescale, .pll_multiplier,
        .pll_postscale, .instr_clk_en, .pin_select_write_ok);

    csp_osc_model i_csp_osc_model (.aclk,
        .osc_en({fast_rc_enable, primary_enable, secondary_enable}),
        .pll_en(pll_enable), .delay, .fail_cmd, .source_ready_pin,
        .pll_lock_pin, .clock_fail_pin);

    task automatic bus_wr(input logic [3:0] a, input logic [15:0] d,
                          output logic [1:0] r);
        @(posedge aclk);
        awv <= 1'b1;
        wv  <= 1'b1;
        awa <= a;
        wd  <= {16'h0000, d};
        br  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        while (bv !== 1'b1);
        r = s_axi_bresp;
        br <= 1'b0;
    endtask : bus_wr

    task automatic rdc(input logic [3:0] a, input logic [31:0] e);
        @(posedge aclk);
        arv <= 1'b1;
        ara <= a;
        rr  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end
        while (rv !== 1'b1);
        `CHK(s_axi_rdata, e)
        rr <= 1'b0;
    endtask : rdc

    task automatic ow(input logic [15:0] d);
        logic [1:0] r;
        bus_wr(4'hC, 16'h00A5, r);
        bus_wr(4'hC, 16'h005A, r);
        bus_wr(4'h0, d, r);
        `CHK(r, 2'h0)
    endtask : ow

    task automatic t_reset;
        logic x;
        rdc(4'h0, 32'h0000_7700);
        rdc(4'h4, 32'h0000_0040);
        rdc(4'h8, 32'h0000_0030);
        `CHK(primary_submode, 2'h2)
        `CHK(slow_rc_enable, 1'b1)
        `CHK(pin_select_write_ok, 1'b1)
        x = instr_clk_en;
        @(posedge aclk);
        `CHK(instr_clk_en, !x)
    endtask : t_reset

    task automatic t_div;
        logic [1:0]  r;
        logic [15:0] v;
        logic [3:0]  post [4] = '{4'h2, 4'h4, 4'h0, 4'h8};
        for (int i = 0; i < 8; i++)
        begin
            v = {5'h00, i[2:0], i[1:0], 1'b0, i[2:0], i[1:0]};
            bus_wr(4'h4, v, r);
            rdc(4'h4, {16'h0000, v});
            `CHK(fast_rc_divide, (i == 7) ? 9'h100 : 9'h001 << i)
            `CHK(pll_postscale, post[i % 4])
            `CHK(pll_prescale, {1'b0, i[2:0], i[1:0]} + 6'h02)
        end
        bus_wr(4'h8, 16'hFFFF, r);
        rdc(4'h8, 32'h0000_01FF);
        `CHK(pll_multiplier, 10'h201)
        bus_wr(4'h8, 16'h0000, r);
        `CHK(pll_multiplier, 10'h002)
        bus_wr(4'h6, 16'h0000, r);
        `CHK(r, 2'h2)
    endtask : t_div

    task automatic t_unlock;
        logic [1:0] r;
        bus_wr(4'h0, 16'h0202, r);
        rdc(4'h0, 32'h0000_7700);
        bus_wr(4'hC, 16'h00A5, r);
        bus_wr(4'hC, 16'h005A, r);
        bus_wr(4'h8, 16'h0030, r);
        bus_wr(4'h0, 16'h0202, r);
        rdc(4'h0, 32'h0000_7700);
        ow(16'h0202);
        rdc(4'h0, 32'h0000_7202);
        `CHK(secondary_enable, 1'b1)
        ow(16'h0700);
        `CHK(secondary_enable, 1'b0)
    endtask : t_unlock

    task automatic t_switch(input logic [2:0] s, input logic [7:0] dl,
                            input logic lk);
        int n = 0;
        int c = n_chg;
        delay <= dl;
        ow({5'h00, s, 8'h01});
        repeat (2) @(posedge aclk);
        while (switch_busy !== 1'b0 && n < 500)
        begin
            @(posedge aclk);
            n++;
        end
        repeat (2) @(posedge aclk);
        `CHK(switch_busy, 1'b0)
        `CHK(active_source, s)
        `CHK(n_chg, c + 1)
        rdc(4'h0, {17'h0, s, 1'b0, s, 2'h0, lk, 5'h00});
    endtask : t_switch

    task automatic t_fail;
        fail_cmd <= 1'b1;
        repeat (4) @(posedge aclk);
        fail_cmd <= 1'b0;
        repeat (4) @(posedge aclk);
        rdc(4'h0, 32'h0000_7708);
        ow(16'h0700);
        rdc(4'h0, 32'h0000_7700);
    endtask : t_fail

    task automatic t_locks;
        ow(16'h0740);
        `CHK(pin_select_write_ok, 1'b0)
        ow(16'h07C0);
        ow(16'h02C1);
        repeat (40) @(posedge aclk);
        `CHK(active_source, 3'h7)
        rdc(4'h0, 32'h0000_77C0);
    endtask : t_locks

    task automatic t_config;
        aresetn <= 1'b0;
        cfg_src <= 3'h5;
        cfg_sub <= 2'h1;
        cfg_sw  <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rdc(4'h0, 32'h0000_5500);
        `CHK(primary_submode, 2'h1)
        ow(16'h0301);
        repeat (20) @(posedge aclk);
        `CHK(active_source, 3'h5)
        rdc(4'h0, 32'h0000_5300);
    endtask : t_config

    task automatic end_of_test;
        if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_of_test

    initial
    begin
        #(100 * 30000);
        n_errors++;
        end_of_test;
    end

    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset;
        t_div;
        t_unlock;
        t_switch(3'h2, 8'h28, 1'b0);
        t_switch(3'h3, 8'h03, 1'b1);
        t_switch(3'h0, 8'h03, 1'b0);
        t_switch(3'h1, 8'h28, 1'b1);
        t_switch(3'h7, 8'h03, 1'b0);
        t_fail;
        t_locks;
        t_config;
        end_of_test;
    end
endmodule : csp_clock_select_bench
